// file: dual_timer_counter_unit.sv
// Dual 16-bit timer/counter unit with mode and control registers
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Timer function counts low byte once per 12-clock machine cycle.
// - Counter function counts falling edges on the unit's count pin.
// - Count pin sampled once per machine cycle; high then low registers one count.
// - Detected edge shows in the count at update phase of next cycle.
// - Each unit has high and low count bytes, joined or split by mode.
// - Mode register resets to zero and accepts whole-byte writes only.
// - Unit one gate set: counts only while irq pin one high and run set.
// - Mode bit 6 picks count pin or machine cycles for unit one.
// - Unit one mode field: prescaled, cascade, auto-reload, stopped.
// - Unit zero gate set: counts only while irq pin zero high and run set.
// - Mode bit 2 picks count pin or machine cycles for unit zero.
// - Unit zero modes 00, 01, 10 behave as unit one's.
// - Unit zero split: low byte own controls, high byte timer on unit one controls.
// - Control register resets to zero and allows single-bit writes.
// - Prescaled mode uses high byte plus low five bits; rollover sets overflow.
// - Overflow sets flag; vector acknowledge clears it.
// - Counting needs run bit; setting run keeps the count.
// - Reload copies high into low, high kept; unit one split holds count.
module dual_timer_counter_unit (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_clk_en,
	input  wire dual_timer_pkg::sfr_req_t i_sfr_req,
	input  wire logic                     i_vector_ack_zero,
	input  wire logic                     i_vector_ack_one,
	input  wire logic                     i_count_pin_zero,
	input  wire logic                     i_count_pin_one,
	input  wire logic                     i_ext_irq_pin_zero,
	input  wire logic                     i_ext_irq_pin_one,
	output logic [7:0]                    o_sfr_rdata,
	output logic                          o_unit_zero_overflow,
	output logic                          o_unit_one_overflow
);
	import dual_timer_pkg::*;

	// ==========================================================
	// Declarations
	logic [3:0]           phase;
	logic [3:0]           next_phase;
	logic [PIN_COUNT-1:0] pin_raw;
	logic [PIN_COUNT-1:0] sync1;
	logic [PIN_COUNT-1:0] sync2;
	logic [PIN_COUNT-1:0] sync3;
	logic [PIN_COUNT-1:0] pin_lvl;
	logic [PIN_COUNT-1:0] next_pin_lvl;
	logic [1:0]           last_sample;
	logic [1:0]           next_last_sample;
	logic [1:0]           pend;
	logic [1:0]           next_pend;
	logic [1:0][7:0]      cnt_low;
	logic [1:0][7:0]      cnt_high;
	logic [1:0][7:0]      next_low;
	logic [1:0][7:0]      next_high;
	timer_mode_select_t   mode;
	timer_mode_select_t   next_mode;
	timer_control_t       ctl;
	timer_control_t       next_ctl;
	logic [7:0]           ctl_bits;
	logic [7:0]           rdata;
	logic [7:0]           next_rdata;
	unit_mode_t [1:0]     unit_cfg;
	logic [1:0]           unit_run;
	logic [1:0]           tick;
	logic [1:0]           set_ovf;
	logic                 mcycle;
	logic                 sample_now;

	assign pin_raw = {i_ext_irq_pin_one, i_ext_irq_pin_zero, i_count_pin_one, i_count_pin_zero};
	assign unit_cfg = {mode.unit_one, mode.unit_zero};
	assign unit_run = {ctl.unit_one_run, ctl.unit_zero_run};
	assign mcycle = (phase == UPDATE_PHASE);
	assign sample_now = (phase == SAMPLE_PHASE);

	// ==========================================================
	// Machine cycle phase
	always_comb begin
		next_phase = (phase == PHASE_LAST) ? PHASE_FIRST : phase + 4'h1;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase <= PHASE_FIRST;
		end else if (i_clk_en) begin
			phase <= next_phase;
		end
	end

	// ==========================================================
	// Pin synchronisers
	always_comb begin
		next_pin_lvl = pin_lvl;
		for (int p = 0; p < PIN_COUNT; p++) begin
			if (sync2[p] == sync3[p]) begin
				next_pin_lvl[p] = sync3[p];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1   <= '0;
			sync2   <= '0;
			sync3   <= '0;
			pin_lvl <= '0;
		end else if (i_clk_en) begin
			sync1   <= pin_raw;
			sync2   <= sync1;
			sync3   <= sync2;
			pin_lvl <= next_pin_lvl;
		end
	end

	// ==========================================================
	// Falling edge detection on count pins
	always_comb begin
		next_last_sample = last_sample;
		next_pend = pend;
		if (mcycle) begin
			next_pend = 2'b00;
		end
		if (sample_now) begin
			next_last_sample = {pin_lvl[PIN_CNT_ONE], pin_lvl[PIN_CNT_ZERO]};
			next_pend[0] = last_sample[0] & ~pin_lvl[PIN_CNT_ZERO];
			next_pend[1] = last_sample[1] & ~pin_lvl[PIN_CNT_ONE];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			last_sample <= 2'b00;
			pend        <= 2'b00;
		end else if (i_clk_en) begin
			last_sample <= next_last_sample;
			pend        <= next_pend;
		end
	end

	// ==========================================================
	// Count enables
	always_comb begin
		tick = 2'b00;
		for (int u = 0; u < 2; u++) begin
			// Source select, gate and run
			tick[u] = mcycle & unit_run[u]
				& (~unit_cfg[u].gate | pin_lvl[PIN_IRQ_ZERO + u])
				& (unit_cfg[u].counter_src ? pend[u] : 1'b1);
		end
	end

	// ==========================================================
	// Count registers
	always_comb begin
		next_low = cnt_low;
		next_high = cnt_high;
		set_ovf = 2'b00;
		for (int u = 0; u < 2; u++) begin
			unique case (unit_cfg[u].sel)
				MODE_PRESCALED: begin
					if (tick[u]) begin
						// Upper three low bits left untouched
						next_low[u][4:0] = cnt_low[u][4:0] + LOW5_ONE;
						if (cnt_low[u][4:0] == LOW5_MAX) begin
							next_high[u] = cnt_high[u] + BYTE_ONE;
							set_ovf[u] = (cnt_high[u] == BYTE_MAX);
						end
					end
				end
				MODE_CASCADE: begin
					if (tick[u]) begin
						next_low[u] = cnt_low[u] + BYTE_ONE;
						if (cnt_low[u] == BYTE_MAX) begin
							next_high[u] = cnt_high[u] + BYTE_ONE;
							set_ovf[u] = (cnt_high[u] == BYTE_MAX);
						end
					end
				end
				MODE_RELOAD: begin
					if (tick[u]) begin
						if (cnt_low[u] == BYTE_MAX) begin
							next_low[u] = cnt_high[u];
							set_ovf[u] = 1'b1;
						end else begin
							next_low[u] = cnt_low[u] + BYTE_ONE;
						end
					end
				end
				MODE_SPLIT: begin
					if (u == 0 && tick[u]) begin
						next_low[u] = cnt_low[u] + BYTE_ONE;
						set_ovf[u] = (cnt_low[u] == BYTE_MAX);
					end
				end
			endcase
		end
		// Split unit zero high byte takes over unit one run and flag
		if (mode.unit_zero.sel == MODE_SPLIT) begin
			set_ovf[1] = 1'b0;
			if (mcycle && ctl.unit_one_run) begin
				next_high[0] = cnt_high[0] + BYTE_ONE;
				set_ovf[1] = (cnt_high[0] == BYTE_MAX);
			end
		end
		// Software byte writes win over hardware updates
		if (i_sfr_req.wr) begin
			unique case (i_sfr_req.addr)
				ADDR_LOW_ZERO: next_low[0] = i_sfr_req.wdata;
				ADDR_LOW_ONE: next_low[1] = i_sfr_req.wdata;
				ADDR_HIGH_ZERO: next_high[0] = i_sfr_req.wdata;
				ADDR_HIGH_ONE: next_high[1] = i_sfr_req.wdata;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_low  <= {COUNT_RESET, COUNT_RESET};
			cnt_high <= {COUNT_RESET, COUNT_RESET};
		end else if (i_clk_en) begin
			cnt_low  <= next_low;
			cnt_high <= next_high;
		end
	end

	// ==========================================================
	// Mode and control registers
	always_comb begin
		next_mode = mode;
		next_ctl = ctl;
		if (i_vector_ack_zero) begin
			next_ctl.unit_zero_overflow = 1'b0;
		end
		if (i_vector_ack_one) begin
			next_ctl.unit_one_overflow = 1'b0;
		end
		ctl_bits = next_ctl;
		if (i_sfr_req.wr && i_sfr_req.addr == ADDR_MODE) begin
			next_mode = timer_mode_select_t'(i_sfr_req.wdata);
		end
		if (i_sfr_req.wr && i_sfr_req.addr == ADDR_CONTROL) begin
			next_ctl = timer_control_t'(i_sfr_req.wdata);
		end else if (i_sfr_req.bit_wr && i_sfr_req.addr == ADDR_CONTROL) begin
			ctl_bits[i_sfr_req.bit_sel] = i_sfr_req.bit_val;
			next_ctl = timer_control_t'(ctl_bits);
		end
		next_ctl.ext_bits = CONTROL_RSVD;
		// Hardware set beats any clear in the same cycle
		next_ctl.unit_zero_overflow = next_ctl.unit_zero_overflow | set_ovf[0];
		next_ctl.unit_one_overflow = next_ctl.unit_one_overflow | set_ovf[1];
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode <= timer_mode_select_t'(MODE_RESET);
			ctl  <= timer_control_t'(CONTROL_RESET);
		end else if (i_clk_en) begin
			mode <= next_mode;
			ctl  <= next_ctl;
		end
	end

	// ==========================================================
	// Read data
	always_comb begin
		unique case (i_sfr_req.addr)
			ADDR_CONTROL: next_rdata = ctl;
			ADDR_MODE: next_rdata = mode;
			ADDR_LOW_ZERO: next_rdata = cnt_low[0];
			ADDR_LOW_ONE: next_rdata = cnt_low[1];
			ADDR_HIGH_ZERO: next_rdata = cnt_high[0];
			ADDR_HIGH_ONE: next_rdata = cnt_high[1];
			default: next_rdata = READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata <= READ_UNMAPPED;
		end else if (i_clk_en) begin
			rdata <= next_rdata;
		end
	end

	assign o_sfr_rdata = rdata;
	assign o_unit_zero_overflow = ctl.unit_zero_overflow;
	assign o_unit_one_overflow = ctl.unit_one_overflow;

	// ==========================================================
	// Assertions
	phase_wrap_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && phase == PHASE_LAST) |=> (phase == PHASE_FIRST))
		else $error("phase did not wrap after twelve clocks");
	count_phase_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && phase != UPDATE_PHASE && !i_sfr_req.wr)
		|=> ($stable(cnt_low) && $stable(cnt_high)))
		else $error("count changed outside update phase");
	sample_phase_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && !pend[0] && phase != SAMPLE_PHASE) |=> !pend[0])
		else $error("edge detected outside sample phase");
	fall_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && mcycle && pend[0] && ctl.unit_zero_run && mode.unit_zero.counter_src
		&& !mode.unit_zero.gate && mode.unit_zero.sel == MODE_CASCADE && !i_sfr_req.wr)
		|=> (cnt_low[0] == $past(cnt_low[0]) + BYTE_ONE))
		else $error("falling edge not counted");
	mode_byte_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && i_sfr_req.bit_wr && !i_sfr_req.wr) |=> $stable(mode))
		else $error("mode register changed by bit write");
	gate_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && mode.unit_zero.gate && !pin_lvl[PIN_IRQ_ZERO] && !i_sfr_req.wr)
		|=> $stable(cnt_low[0]))
		else $error("gated unit zero counted with irq pin low");
	auto_reload_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && mode.unit_zero.sel == MODE_RELOAD && tick[0]
		&& cnt_low[0] == BYTE_MAX && !i_sfr_req.wr)
		|=> (cnt_low[0] == $past(cnt_high[0]) && $stable(cnt_high[0]) && ctl.unit_zero_overflow))
		else $error("auto reload wrong");
	split_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && mode.unit_one.sel == MODE_SPLIT && !i_sfr_req.wr)
		|=> ($stable(cnt_low[1]) && $stable(cnt_high[1])))
		else $error("stopped unit one changed");
	sw_wins_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && i_sfr_req.wr && i_sfr_req.addr == ADDR_LOW_ZERO)
		|=> (cnt_low[0] == $past(i_sfr_req.wdata)))
		else $error("software write lost to hardware");
	ovf_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && set_ovf[0]) |=> ctl.unit_zero_overflow)
		else $error("overflow flag not set");

endmodule

`default_nettype wire

// file: dual_timer_counter_unit_bench.sv
// Self-checking bench of the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
	$display("wrong value %s exp %0h got %0h", nm, ex, got); end end

module dual_timer_counter_unit_bench;
	import dual_timer_pkg::*;

	// ==========================================================
	// Signals
	logic       i_sys_clk = 1'b0;
	logic       i_rst_n   = 1'b0;
	logic       i_clk_en  = 1'b1;
	sfr_req_t   req       = '0;
	logic       ack0      = 1'b0;
	logic       ack1      = 1'b0;
	logic       cnt0      = 1'b1;
	logic       cnt1      = 1'b1;
	logic       irq0      = 1'b1;
	logic       irq1      = 1'b1;
	logic [7:0] rdata;
	logic       ovf0;
	logic       ovf1;
	int         error_cnt = 0;
	int         checks    = 0;

	always #12.5 i_sys_clk = ~i_sys_clk;

	dual_timer_counter_unit dut_u (
		.i_sys_clk           (i_sys_clk),
		.i_rst_n             (i_rst_n),
		.i_clk_en            (i_clk_en),
		.i_sfr_req           (req),
		.i_vector_ack_zero   (ack0),
		.i_vector_ack_one    (ack1),
		.i_count_pin_zero    (cnt0),
		.i_count_pin_one     (cnt1),
		.i_ext_irq_pin_zero  (irq0),
		.i_ext_irq_pin_one   (irq1),
		.o_sfr_rdata         (rdata),
		.o_unit_zero_overflow(ovf0),
		.o_unit_one_overflow (ovf1)
	);

	// ==========================================================
	// Bus tasks
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic stop_test;
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask

	task automatic wr_bit(input logic [7:0] a, input logic [2:0] b, input logic v);
		req.addr = a;
		req.bit_sel = b;
		req.bit_val = v;
		req.bit_wr = 1'b1;
		tick(1);
		req.bit_wr = 1'b0;
		tick(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		req.addr = a;
		tick(1);
		d = rdata;
	endtask

	task automatic wait_ovf(input logic one, input int bound);
		int n;
		n = 0;
		while ((one ? ovf1 : ovf0) !== 1'b1 && n < bound) begin
			tick(1);
			n++;
		end
		if (n >= bound) begin
			error_cnt++;
			stop_test();
		end
	endtask

	task automatic wait_change(output int n);
		logic [7:0] prv;
		prv = rdata;
		n = 0;
		while (rdata === prv && n < 40) begin
			tick(1);
			n++;
		end
		if (n >= 40) begin
			error_cnt++;
			stop_test();
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [7:0] d;
		rd(ADDR_CONTROL, d); `CHK("control reset", 8'h00, d)
		rd(ADDR_MODE, d); `CHK("mode reset", 8'h00, d)
		wr_byte(ADDR_MODE, 8'h5A);
		wr_bit(ADDR_MODE, 3'h0, 1'b1);
		rd(ADDR_MODE, d); `CHK("mode byte only", 8'h5A, d)
		wr_byte(ADDR_CONTROL, 8'h0F);
		rd(ADDR_CONTROL, d); `CHK("control low bits", 8'h00, d)
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		wr_bit(ADDR_CONTROL, 3'h6, 1'b1);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b0);
		rd(ADDR_CONTROL, d); `CHK("control bit write", 8'h40, d)
		wr_byte(ADDR_CONTROL, 8'h00);
		rd(8'h90, d); `CHK("unmapped read", 8'h00, d)
	endtask

	task automatic t_rate_and_priority;
		int n;
		wr_byte(ADDR_MODE, 8'h01);
		wr_byte(ADDR_LOW_ZERO, 8'h00);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		req.addr = ADDR_LOW_ZERO;
		wait_change(n);
		wait_change(n);
		wait_change(n);
		`CHK("timer period", 12, n)
		req.wdata = 8'h77;
		req.wr = 1'b1;
		for (int i = 0; i < 14; i++) begin
			tick(1);
			if (i > 0) `CHK("write beats count", 8'h77, rdata)
		end
		req.wr = 1'b0;
		tick(1);
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_overflow16;
		logic [7:0] d;
		wr_byte(ADDR_HIGH_ZERO, 8'hFF);
		wr_byte(ADDR_LOW_ZERO, 8'hFF);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		wait_ovf(1'b0, 30);
		rd(ADDR_LOW_ZERO, d); `CHK("cascade low", 8'h00, d)
		rd(ADDR_HIGH_ZERO, d); `CHK("cascade high", 8'h00, d)
		ack0 = 1'b1;
		tick(1);
		ack0 = 1'b0;
		tick(1);
		`CHK("ack clears flag", 1'b0, ovf0)
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_prescaled;
		logic [7:0] d;
		wr_byte(ADDR_MODE, 8'h00);
		wr_byte(ADDR_HIGH_ZERO, 8'hFF);
		wr_byte(ADDR_LOW_ZERO, 8'hFF);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		wait_ovf(1'b0, 30);
		rd(ADDR_LOW_ZERO, d); `CHK("prescale low five", 5'h00, d[4:0])
		rd(ADDR_HIGH_ZERO, d); `CHK("prescale high", 8'h00, d)
		wr_byte(ADDR_CONTROL, 8'h00);
		`CHK("software clear", 1'b0, ovf0)
	endtask

	task automatic t_reload;
		logic [7:0] d;
		wr_byte(ADDR_MODE, 8'h22);
		wr_byte(ADDR_HIGH_ONE, 8'hA0);
		wr_byte(ADDR_LOW_ONE, 8'hFE);
		wr_byte(ADDR_HIGH_ZERO, 8'h5C);
		wr_byte(ADDR_LOW_ZERO, 8'hFE);
		wr_byte(ADDR_CONTROL, 8'h50);
		wait_ovf(1'b1, 40);
		`CHK("reload flag zero", 1'b1, ovf0)
		rd(ADDR_LOW_ONE, d); `CHK("reload low", 8'hA0, d)
		rd(ADDR_HIGH_ONE, d); `CHK("reload keeps high", 8'hA0, d)
		rd(ADDR_LOW_ZERO, d); `CHK("reload low zero", 8'h5C, d)
		ack0 = 1'b1;
		ack1 = 1'b1;
		tick(1);
		ack0 = 1'b0;
		ack1 = 1'b0;
		tick(1);
		`CHK("ack one clears", 1'b0, ovf1)
		`CHK("ack zero clears", 1'b0, ovf0)
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_counter;
		logic [7:0] d;
		wr_byte(ADDR_MODE, 8'h05);
		wr_byte(ADDR_LOW_ZERO, 8'h00);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		// Each level held two machine cycles
		for (int i = 0; i < 3; i++) begin
			cnt0 = 1'b1;
			tick(24);
			cnt0 = 1'b0;
			tick(24);
		end
		cnt0 = 1'b1;
		tick(30);
		rd(ADDR_LOW_ZERO, d); `CHK("falling edges", 8'h03, d)
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_gate_and_run;
		logic [7:0] d;
		wr_byte(ADDR_MODE, 8'h90);
		wr_byte(ADDR_LOW_ONE, 8'h40);
		tick(40);
		rd(ADDR_LOW_ONE, d); `CHK("stopped without run", 8'h40, d)
		irq1 = 1'b0;
		tick(6);
		wr_bit(ADDR_CONTROL, 3'h6, 1'b1);
		rd(ADDR_LOW_ONE, d); `CHK("run keeps count", 8'h40, d)
		tick(60);
		rd(ADDR_LOW_ONE, d); `CHK("gate low holds", 8'h40, d)
		irq1 = 1'b1;
		tick(60);
		rd(ADDR_LOW_ONE, d); `CHK("gate high counts", 1'b1, d > 8'h43)
		wr_byte(ADDR_MODE, 8'h08);
		wr_byte(ADDR_LOW_ZERO, 8'h00);
		irq0 = 1'b0;
		tick(6);
		wr_bit(ADDR_CONTROL, 3'h4, 1'b1);
		tick(60);
		rd(ADDR_LOW_ZERO, d); `CHK("gate zero holds", 8'h00, d)
		irq0 = 1'b1;
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	task automatic t_split;
		logic [7:0] d;
		wr_byte(ADDR_MODE, 8'h33);
		wr_byte(ADDR_HIGH_ZERO, 8'hFF);
		wr_byte(ADDR_LOW_ZERO, 8'h21);
		wr_byte(ADDR_LOW_ONE, 8'h10);
		wr_bit(ADDR_CONTROL, 3'h6, 1'b1);
		wait_ovf(1'b1, 30);
		`CHK("split low flag", 1'b0, ovf0)
		rd(ADDR_LOW_ZERO, d); `CHK("split low idle", 8'h21, d)
		tick(40);
		rd(ADDR_LOW_ONE, d); `CHK("unit one holds", 8'h10, d)
		wr_byte(ADDR_CONTROL, 8'h00);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		tick(5);
		i_rst_n = 1'b1;
		tick(1);
		t_regs();
		t_rate_and_priority();
		t_overflow16();
		t_prescaled();
		t_reload();
		t_counter();
		t_gate_and_run();
		t_split();
		stop_test();
	end

endmodule

`default_nettype wire

// file: dual_timer_pkg.sv
// Constants, types and register layout of the dual timer/counter unit
package dual_timer_pkg;

	// ==========================================================
	// Machine cycle timing
	localparam int unsigned MACHINE_CYCLE_CLKS = 12;
	localparam logic [3:0]  PHASE_FIRST        = 4'h0;
	localparam logic [3:0]  PHASE_LAST         = 4'(MACHINE_CYCLE_CLKS - 1);
	// Sample phase: state 5, phase 2
	localparam logic [3:0]  SAMPLE_PHASE       = 4'h9;
	// Update phase: state 3, phase 1
	localparam logic [3:0]  UPDATE_PHASE       = 4'h4;

	// ==========================================================
	// Register byte addresses
	localparam logic [7:0] ADDR_CONTROL   = 8'h88;
	localparam logic [7:0] ADDR_MODE      = 8'h89;
	localparam logic [7:0] ADDR_LOW_ZERO  = 8'h8A;
	localparam logic [7:0] ADDR_LOW_ONE   = 8'h8B;
	localparam logic [7:0] ADDR_HIGH_ZERO = 8'h8C;
	localparam logic [7:0] ADDR_HIGH_ONE  = 8'h8D;

	// ==========================================================
	// Reset values and count limits
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	localparam logic [3:0] CONTROL_RSVD  = 4'h0;
	localparam logic [4:0] LOW5_MAX      = 5'h1F;
	localparam logic [4:0] LOW5_ONE      = 5'h01;
	localparam logic [7:0] BYTE_MAX      = 8'hFF;
	localparam logic [7:0] BYTE_ONE      = 8'h01;

	// ==========================================================
	// Pin vector positions
	localparam int unsigned PIN_COUNT     = 4;
	localparam int unsigned PIN_CNT_ZERO  = 0;
	localparam int unsigned PIN_CNT_ONE   = 1;
	localparam int unsigned PIN_IRQ_ZERO  = 2;
	localparam int unsigned PIN_IRQ_ONE   = 3;

	// ==========================================================
	// Field layouts
	typedef enum logic [1:0] {
		MODE_PRESCALED = 2'b00,
		MODE_CASCADE   = 2'b01,
		MODE_RELOAD    = 2'b10,
		MODE_SPLIT     = 2'b11
	} mode_t;

	typedef struct packed {
		logic  gate;
		logic  counter_src;
		mode_t sel;
	} unit_mode_t;

	// Bit 7..4 unit one, bit 3..0 unit zero
	typedef struct packed {
		unit_mode_t unit_one;
		unit_mode_t unit_zero;
	} timer_mode_select_t;

	// Bit 7 ovf one, 6 run one, 5 ovf zero, 4 run zero, 3..0 read zero
	typedef struct packed {
		logic       unit_one_overflow;
		logic       unit_one_run;
		logic       unit_zero_overflow;
		logic       unit_zero_run;
		logic [3:0] ext_bits;
	} timer_control_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
		logic       bit_wr;
		logic [2:0] bit_sel;
		logic       bit_val;
	} sfr_req_t;

endpackage
